/* rtl/arf_top.sv */
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "arf_defines.svh"
module arf_top #(
    parameter int N_CH   = 8,
    parameter int DATA_W = 10
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire arf_pkg::arf_addr_t  s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    input  wire arf_pkg::arf_word_t  s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    output logic [1:0]               s_axi_bresp,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    input  wire arf_pkg::arf_addr_t  s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    output arf_pkg::arf_word_t       s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    input  wire logic                conv_done,
    input  wire logic [2:0]          conv_channel,
    input  wire logic [DATA_W-1:0]   conv_data,
    output logic                     conv_start,
    output logic                     core_sleep,
    output logic [N_CH-1:0]          chan_enable,
    output logic                     irq
);
    import arf_pkg::*;

    localparam int CW = $clog2(N_CH);

    typedef struct packed {
        logic                        aw_got;
        arf_addr_t                   awaddr;
        logic                        w_got;
        arf_word_t                   wdata;
        logic [3:0]                  wstrb;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        rvalid;
        arf_word_t                   rdata;
        logic [1:0]                  rresp;
        logic                        awready;
        logic                        wready;
        logic                        arready;
        logic [N_CH-1:0]             en;
        logic                        sleep_mode;
        logic                        sleeping;
        logic                        start;
        logic                        data_ready_flag;
        logic                        global_overrun_flag;
        logic [DATA_W-1:0]           last;
        logic [CW-1:0]               last_ch;
        logic [N_CH-1:0][DATA_W-1:0] res;
    } arf_top_s;

    arf_top_s        st_reg;
    arf_top_s        st_next;
    logic [N_CH-1:0] eoc;
    logic [N_CH-1:0] channel_overrun_flag;
    logic [N_CH-1:0] new_eoc;
    logic [N_CH-1:0] clr_eoc;
    logic            clr_ovr;
    logic            do_wr;
    logic            do_rd;
    arf_reg_e        wsel;
    arf_reg_e        rsel;
    logic [CW-1:0]   rch;
    arf_word_t       wd;
    arf_word_t       rval;
    logic            any_new;

    arf_irq_if #(.W(`ARF_IRQ_W)) irq_bus ();

    function automatic arf_reg_e decode(input arf_addr_t a);
        arf_reg_e r;
        r = ARF_R_NONE;
        if (a[1:0] != 2'b00) begin
            r = ARF_R_NONE;
        end else if (a >= `ARF_RES_BASE
                     && a < `ARF_RES_BASE + 8'(4 * N_CH)) begin
            r = ARF_R_RES;
        end else begin
            unique case (a)
                `ARF_CTRL_OFF:   r = ARF_R_CTRL;
                `ARF_MODE_OFF:   r = ARF_R_MODE;
                `ARF_CHEN_OFF:   r = ARF_R_CHEN;
                `ARF_CHDIS_OFF:  r = ARF_R_CHDIS;
                `ARF_CHSR_OFF:   r = ARF_R_CHSR;
                `ARF_STATUS_OFF: r = ARF_R_STATUS;
                `ARF_LAST_OFF:   r = ARF_R_LAST;
                `ARF_ISR_OFF:    r = ARF_R_ISR;
                `ARF_IMR_OFF:    r = ARF_R_IMR;
                default:         r = ARF_R_NONE;
            endcase
        end
        return r;
    endfunction : decode

    // Bus handshakes and address decode
    assign do_wr = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    assign do_rd = s_axi_arvalid && !st_reg.rvalid;
    assign wsel  = do_wr ? decode(st_reg.awaddr) : ARF_R_NONE;
    assign rsel  = do_rd ? decode(s_axi_araddr) : ARF_R_NONE;
    assign rch   = CW'((s_axi_araddr - `ARF_RES_BASE) >> 2);
    assign wd    = st_reg.wdata & {{8{st_reg.wstrb[3]}}, {8{st_reg.wstrb[2]}},
                                   {8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};

    // Only an enabled channel stores data and raises flags
    assign any_new = conv_done && st_reg.en[conv_channel];

    always_comb begin
        new_eoc = '0;
        clr_eoc = '0;
        if (any_new) begin
            new_eoc[conv_channel] = 1'b1;
        end
        if (rsel == ARF_R_RES) begin
            clr_eoc[rch] = 1'b1;
        end
        if (rsel == ARF_R_LAST) begin
            clr_eoc[st_reg.last_ch] = 1'b1;
        end
    end
    assign clr_ovr = (rsel == ARF_R_STATUS);

    genvar gi;
    generate
        for (gi = 0; gi < N_CH; gi++) begin : g_ch
            arf_chan_flags u_flags (
                .aclk    (aclk),
                .aresetn (aresetn),
                .new_eoc (new_eoc[gi]),
                .clr_eoc (clr_eoc[gi]),
                .clr_ovr (clr_ovr),
                .eoc     (eoc[gi]),
                .channel_overrun_flag    (channel_overrun_flag[gi])
            );
        end
    endgenerate

    // Read data reflects the state before this cycle's update
    always_comb begin
        rval = '0;
        unique case (rsel)
            ARF_R_MODE:   rval[`ARF_MODE_SLEEP] = st_reg.sleep_mode;
            ARF_R_CHSR:   rval[N_CH-1:0] = st_reg.en;
            ARF_R_STATUS: begin
                rval[N_CH-1:0] = eoc;
                rval[`ARF_ST_OVR_LSB +: N_CH] = channel_overrun_flag;
                rval[`ARF_ST_DATA_READY_FLAG]  = st_reg.data_ready_flag;
                rval[`ARF_ST_GLOBAL_OVERRUN_FLAG] = st_reg.global_overrun_flag;
                rval[`ARF_ST_SLEEP] = st_reg.sleeping;
            end
            ARF_R_LAST: begin
                rval[DATA_W-1:0] = st_reg.last;
                rval[`ARF_LAST_CH_LSB +: CW] = st_reg.last_ch;
            end
            ARF_R_ISR:    rval[`ARF_IRQ_W-1:0] = irq_bus.status;
            ARF_R_IMR:    rval[`ARF_IRQ_W-1:0] = irq_bus.mask;
            ARF_R_RES:    rval[DATA_W-1:0] = st_reg.res[rch];
            default:      rval = '0;
        endcase
    end

    always_comb begin
        st_next       = st_reg;
        st_next.start = 1'b0;
        // Write address and data are taken in either order
        if (s_axi_awvalid && !st_reg.aw_got) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_got) begin
            st_next.w_got = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (do_wr) begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = (wsel == ARF_R_NONE) ? `ARF_RESP_SLVERR : `ARF_RESP_OKAY;
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (do_rd) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rval;
            st_next.rresp  = (rsel == ARF_R_NONE) ? `ARF_RESP_SLVERR : `ARF_RESP_OKAY;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        // Register writes
        unique case (wsel)
            ARF_R_CTRL:  st_next.start = wd[`ARF_CTRL_START];
            ARF_R_MODE: begin
                if (st_reg.wstrb[0]) begin
                    st_next.sleep_mode = wd[`ARF_MODE_SLEEP];
                end
            end
            ARF_R_CHEN:  st_next.en = st_reg.en | wd[N_CH-1:0];
            ARF_R_CHDIS: st_next.en = st_reg.en & ~wd[N_CH-1:0];
            default:     st_next.en = st_reg.en;
        endcase
        // Result storage on an enabled end of conversion
        if (any_new) begin
            st_next.res[conv_channel] = conv_data;
            st_next.last              = conv_data;
            st_next.last_ch           = CW'(conv_channel);
        end
        // Data-ready: set wins, only a last-result read clears it
        if (any_new) begin
            st_next.data_ready_flag = 1'b1;
        end else if (rsel == ARF_R_LAST) begin
            st_next.data_ready_flag = 1'b0;
        end
        // Global overrun: set by a new result over unread data
        if (any_new && st_reg.data_ready_flag) begin
            st_next.global_overrun_flag = 1'b1;
        end else if (rsel == ARF_R_STATUS) begin
            st_next.global_overrun_flag = 1'b0;
        end
        // Sleep taken at the end of a conversion
        if (!st_reg.sleep_mode) begin
            st_next.sleeping = 1'b0;
        end else if (conv_done) begin
            st_next.sleeping = 1'b1;
        end
        // Ready outputs registered from the next hold state
        st_next.awready = !st_next.aw_got;
        st_next.wready  = !st_next.w_got;
        st_next.arready = !st_next.rvalid;
    end

    // Interrupt events and software access
    always_comb begin
        irq_bus.evt = '0;
        irq_bus.evt[`ARF_IRQ_DATA_READY_FLAG]  = any_new;
        irq_bus.evt[`ARF_IRQ_GLOBAL_OVERRUN_FLAG] = any_new && st_reg.data_ready_flag;
        irq_bus.evt[`ARF_IRQ_CHANNEL_OVERRUN_FLAG]  = |(new_eoc & eoc);
        irq_bus.evt[`ARF_IRQ_EOC]   = any_new;
        irq_bus.clr     = (wsel == ARF_R_ISR) ? wd[`ARF_IRQ_W-1:0] : '0;
        irq_bus.mask_we = (wsel == ARF_R_IMR);
        irq_bus.mask_wd = wd[`ARF_IRQ_W-1:0];
    end

    arf_irq u_irq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .bus     (irq_bus)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg         <= '0;
            st_reg.en      <= `ARF_EN_RST;
            st_reg.awready <= 1'b1;
            st_reg.wready  <= 1'b1;
            st_reg.arready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready  = st_reg.wready;
    assign s_axi_bvalid  = st_reg.bvalid;
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid  = st_reg.rvalid;
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    assign conv_start    = st_reg.start;
    assign core_sleep    = st_reg.sleeping;
    assign chan_enable   = st_reg.en;
    assign irq           = irq_bus.irq;
endmodule : arf_top
`default_nettype wire

/* rtl/arf_defines.svh */
`ifndef ARF_DEFINES_SVH
`define ARF_DEFINES_SVH
`define ARF_CTRL_OFF     8'h00
`define ARF_MODE_OFF     8'h04
`define ARF_CHEN_OFF     8'h10
`define ARF_CHDIS_OFF    8'h14
`define ARF_CHSR_OFF     8'h18
`define ARF_STATUS_OFF   8'h1c
`define ARF_LAST_OFF     8'h20
`define ARF_ISR_OFF      8'h24
`define ARF_IMR_OFF      8'h28
`define ARF_RES_BASE     8'h40
`define ARF_CTRL_START   0
`define ARF_MODE_SLEEP   0
`define ARF_ST_OVR_LSB   8
`define ARF_ST_DATA_READY_FLAG      16
`define ARF_ST_GLOBAL_OVERRUN_FLAG     17
`define ARF_ST_SLEEP     18
`define ARF_LAST_CH_LSB  12
`define ARF_IRQ_DATA_READY_FLAG     0
`define ARF_IRQ_GLOBAL_OVERRUN_FLAG    1
`define ARF_IRQ_CHANNEL_OVERRUN_FLAG     2
`define ARF_IRQ_EOC      3
`define ARF_IRQ_W        4
`define ARF_IMR_RST      4'h0
`define ARF_EN_RST       8'h00
`define ARF_RESP_OKAY    2'h0
`define ARF_RESP_SLVERR  2'h2
`endif

/* rtl/arf_pkg.sv */
package arf_pkg;
    typedef logic [31:0] arf_word_t;
    typedef logic [7:0]  arf_addr_t;
    typedef enum logic [3:0] {
        ARF_R_CTRL   = 4'b0000,
        ARF_R_MODE   = 4'b0001,
        ARF_R_CHEN   = 4'b0010,
        ARF_R_CHDIS  = 4'b0011,
        ARF_R_CHSR   = 4'b0100,
        ARF_R_STATUS = 4'b0101,
        ARF_R_LAST   = 4'b0110,
        ARF_R_ISR    = 4'b0111,
        ARF_R_IMR    = 4'b1000,
        ARF_R_RES    = 4'b1001,
        ARF_R_NONE   = 4'b1010
    } arf_reg_e;
endpackage : arf_pkg

/* rtl/arf_irq_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface arf_irq_if #(parameter int W = 4);
    logic [W-1:0] evt;
    logic [W-1:0] clr;
    logic         mask_we;
    logic [W-1:0] mask_wd;
    logic [W-1:0] status;
    logic [W-1:0] mask;
    logic         irq;
    modport ctl (output evt, clr, mask_we, mask_wd, input status, mask, irq);
    modport blk (input evt, clr, mask_we, mask_wd, output status, mask, irq);
endinterface : arf_irq_if
`default_nettype wire

/* rtl/arf_chan_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module arf_chan_flags (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic new_eoc,
    input  wire logic clr_eoc,
    input  wire logic clr_ovr,
    output logic      eoc,
    output logic      channel_overrun_flag
);
    typedef struct packed {
        logic eoc;
        logic channel_overrun_flag;
    } arf_cf_s;
    arf_cf_s st_reg;
    arf_cf_s st_next;

    always_comb begin
        st_next = st_reg;
        if (new_eoc) begin
            st_next.eoc = 1'b1;
        end else if (clr_eoc) begin
            st_next.eoc = 1'b0;
        end
        if (new_eoc && st_reg.eoc) begin
            st_next.channel_overrun_flag = 1'b1;
        end else if (clr_ovr) begin
            st_next.channel_overrun_flag = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign eoc  = st_reg.eoc;
    assign channel_overrun_flag = st_reg.channel_overrun_flag;
endmodule : arf_chan_flags
`default_nettype wire

/* rtl/arf_irq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "arf_defines.svh"
module arf_irq (
    input  wire logic aclk,
    input  wire logic aresetn,
    arf_irq_if.blk    bus
);
    typedef struct packed {
        logic [`ARF_IRQ_W-1:0] status;
        logic [`ARF_IRQ_W-1:0] mask;
        logic                  irq;
    } arf_irq_s;
    arf_irq_s st_reg;
    arf_irq_s st_next;

    always_comb begin
        st_next        = st_reg;
        st_next.status = (st_reg.status & ~bus.clr) | bus.evt;
        if (bus.mask_we) begin
            st_next.mask = bus.mask_wd;
        end
        st_next.irq = |(st_next.status & st_next.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '{status: '0, mask: `ARF_IMR_RST, irq: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.status = st_reg.status;
    assign bus.mask   = st_reg.mask;
    assign bus.irq    = st_reg.irq;
endmodule : arf_irq
`default_nettype wire

/* test/arf_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module arf_top_chk #(
    parameter int N_CH = 8
) (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    input wire arf_pkg::arf_word_t s_axi_rdata,
    input wire logic [1:0]       s_axi_rresp,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             conv_done,
    input wire logic             conv_start,
    input wire logic             core_sleep,
    input wire logic [N_CH-1:0]  chan_enable,
    input wire logic             irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rd_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read ready not inverse of read valid");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == '0)
        else $error("error read with data");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    sleep_entry_a: assert property ($rose(core_sleep) |-> $past(conv_done))
        else $error("sleep entered without conversion end");
    enable_upd_a: assert property ($changed(chan_enable) |-> ##[0:1] s_axi_bvalid)
        else $error("enables changed without write");
    cover property (conv_done && s_axi_arvalid && s_axi_arready);
    cover property ($rose(core_sleep));
    cover property ($rose(irq));
endmodule : arf_top_chk
bind arf_top arf_top_chk #(.N_CH(N_CH)) i_arf_top_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .conv_done(conv_done), .conv_start(conv_start),
    .core_sleep(core_sleep), .chan_enable(chan_enable), .irq(irq)
);
`default_nettype wire

/* test/arf_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "arf_defines.svh"
module arf_top_test;
    import arf_pkg::*;
    logic       aclk, aresetn, awv, wv, bry, arv, rry, cdone;
    logic       awr, wrdy, bv, arr, rv, cstart, csleep, irq;
    arf_addr_t  awa, ara;
    arf_word_t  wd, rdat, d;
    logic [1:0] br, rr, resp;
    logic [2:0] cch;
    logic [9:0] cdat;
    logic [7:0] chen;
    int         bad_count, cmp_count;
    int         start_cnt;

    arf_top i_arf_top (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .conv_done(cdone), .conv_channel(cch), .conv_data(cdat),
        .conv_start(cstart), .core_sleep(csleep), .chan_enable(chen), .irq(irq)
    );

    initial begin
        aclk = 0;
        forever #2.5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        if (cstart === 1'b1) start_cnt <= start_cnt + 1;
    end

    task automatic chk(input arf_word_t got, input arf_word_t exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic ev_on(input logic [2:0] ch);
        cdone <= 1'b1;
        cch   <= ch;
        cdat  <= 10'h150 | 10'(ch);
    endtask : ev_on

    task automatic conv(input logic [2:0] ch);
        ev_on(ch);
        @(posedge aclk);
        cdone <= 1'b0;
        @(posedge aclk);
    endtask : conv

    task automatic wr(input arf_addr_t a, input arf_word_t v, input logic ev = 0,
                      input logic [2:0] ch = 0);
        logic aw_ok;
        logic w_ok;
        aw_ok = 0;
        w_ok = 0;
        awv <= 1'b1;
        wv  <= 1'b1;
        awa <= a;
        wd  <= v;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awr) begin
                aw_ok = 1;
                awv <= 1'b0;
            end
            if (!w_ok && wrdy) begin
                w_ok = 1;
                wv <= 1'b0;
            end
        end
        if (ev) ev_on(ch);
        do begin
            @(posedge aclk);
            if (ev) cdone <= 1'b0;
        end while (!bv);
        resp = br;
    endtask : wr

    task automatic rd(input arf_addr_t a, input logic ev = 0, input logic [2:0] ch = 0);
        arv <= 1'b1;
        ara <= a;
        if (ev) ev_on(ch);
        do @(posedge aclk); while (!arr);
        arv   <= 1'b0;
        if (ev) cdone <= 1'b0;
        do @(posedge aclk); while (!rv);
        d = rdat;
        resp = rr;
    endtask : rd

    task automatic t_init;
        rd(`ARF_CHSR_OFF); chk(d, 32'h0);
        rd(`ARF_IMR_OFF); chk(d, 32'h0);
        chk({30'h0, resp}, 32'h0);
        rd(8'hfc); chk({30'h0, resp}, 32'h2);
        wr(8'hfc, 32'hff); chk({30'h0, resp}, 32'h2);
        wr(`ARF_CHEN_OFF, 32'hff); chk({30'h0, resp}, 32'h0);
        rd(`ARF_CHSR_OFF); chk(d, 32'hff);
        $display("test init done");
    endtask : t_init

    task automatic t_store;
        conv(3'h3);
        rd(`ARF_STATUS_OFF); chk(d, 32'h1_0008);
        rd(8'h4c); chk(d, 32'h153);
        rd(`ARF_STATUS_OFF); chk(d, 32'h1_0000);
        rd(`ARF_LAST_OFF); chk(d, 32'h3153);
        rd(`ARF_STATUS_OFF); chk(d, 32'h0);
        $display("test store done");
    endtask : t_store

    task automatic t_race;
        rd(`ARF_RES_BASE, 1, 3'h4); chk(d, 32'h0);
        rd(`ARF_STATUS_OFF); chk(d, 32'h1_0010);
        rd(`ARF_RES_BASE, 1, 3'h4);
        rd(`ARF_LAST_OFF); chk(d, 32'h4154);
        rd(`ARF_STATUS_OFF, 1, 3'h4); chk(d, 32'h2_1000);
        rd(`ARF_STATUS_OFF); chk(d, 32'h1_0010);
        rd(`ARF_STATUS_OFF, 1, 3'h4); chk(d, 32'h1_0010);
        rd(`ARF_STATUS_OFF); chk(d, 32'h3_1010);
        rd(`ARF_STATUS_OFF); chk(d, 32'h1_0010);
        $display("test race done");
    endtask : t_race

    task automatic t_disable;
        wr(`ARF_CHDIS_OFF, 32'h20, 1, 3'h4);
        chk({24'h0, chen}, 32'hdf);
        rd(`ARF_STATUS_OFF); chk(d, 32'h3_1010);
        rd(`ARF_LAST_OFF, 1, 3'h5); chk(d, 32'h4154);
        rd(`ARF_STATUS_OFF); chk(d, 32'h0);
        $display("test disable done");
    endtask : t_disable

    task automatic t_irq;
        wr(`ARF_ISR_OFF, 32'hf);
        wr(`ARF_IMR_OFF, 32'h1);
        conv(3'h2);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        rd(`ARF_ISR_OFF); chk(d, 32'h9);
        wr(`ARF_IMR_OFF, 32'h0);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        wr(`ARF_ISR_OFF, 32'h1);
        rd(`ARF_ISR_OFF); chk(d, 32'h8);
        wr(`ARF_IMR_OFF, 32'h8);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(`ARF_ISR_OFF, 32'h8);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        $display("test irq done");
    endtask : t_irq

    task automatic t_sleep;
        wr(`ARF_MODE_OFF, 32'h1);
        repeat (2) @(posedge aclk);
        chk({31'h0, csleep}, 32'h0);
        chk(start_cnt, 32'h0);
        wr(`ARF_CTRL_OFF, 32'h1);
        conv(3'h2);
        chk(start_cnt, 32'h1);
        repeat (2) @(posedge aclk);
        chk({31'h0, csleep}, 32'h1);
        rd(`ARF_STATUS_OFF); chk((d >> 18) & 32'h1, 32'h1);
        wr(`ARF_MODE_OFF, 32'h0);
        repeat (2) @(posedge aclk);
        chk({31'h0, csleep}, 32'h0);
        $display("test sleep done");
    endtask : t_sleep

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (6000) @(posedge aclk);
        bad_count++;
        wrap_up();
    end

    initial begin
        {aresetn, awv, wv, bry, arv, rry, cdone} = '0;
        {awa, ara, wd, cch, cdat} = '0;
        bad_count = 0;
        cmp_count = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        bry     <= 1'b1;
        rry     <= 1'b1;
        @(posedge aclk);
        t_init();
        t_store();
        t_race();
        t_disable();
        t_irq();
        t_sleep();
        wrap_up();
    end
endmodule : arf_top_test
`default_nettype wire
